// ### wkt_defs.svh
// Contract
// [R1] timer3 loads reload bytes only at start
// [R2] timer3 count readable as high, low bytes
// [R3] host avoids count reads during reception
// [R4] control bit 7 shows wake-up timer running
// [R5] bit 6 write gates change of running bit
// [R6] auto-trim bit starts trimming on underflow
// [R7] host sets up trim timer before auto-trim
// [R8] auto card-detect starts detection on underflow
// [R9] no card: power down, timer restarts seamlessly; code powers down only with auto-wake set
// [R10] timer3 sets field-on time during detection
// [R11] auto-restart reloads, otherwise stops at zero
// [R12] underflow sets the underflow flag
// [R13] auto-wake wakes system on underflow
// [R14] after procedure, power down only with auto-wake
// [R15] clock field selects divide 1, 8, 16, 32
// [R16] 16-bit down-counter, reload high byte register
// [R17] timer can wake system and start detection
// [R18] full reload loaded at each start event
// [R19] running clears at stop; fields reset zero
`ifndef WKT_DEFS_SVH
`define WKT_DEFS_SVH
// register indices; byte address is four times the index
`define WKT_IDX_T3_RELOAD_HIGH 6'h1F
`define WKT_IDX_T3_RELOAD_LOW 6'h20
`define WKT_IDX_T3_COUNT_HIGH 6'h21
`define WKT_IDX_T3_COUNT_LOW 6'h22
`define WKT_IDX_CONTROL 6'h23
`define WKT_IDX_RELOAD_HIGH 6'h24
`define WKT_IDX_RELOAD_LOW 6'h25
`define WKT_IDX_COUNT_HIGH 6'h26
`define WKT_IDX_COUNT_LOW 6'h27
`define WKT_IDX_STATUS 6'h30
// control field positions
`define WKT_BIT_RUNNING 7
`define WKT_BIT_RUN_CHANGE 6
// status field positions
`define WKT_BIT_FLAG 0
`define WKT_BIT_CARD 1
`define WKT_BIT_PDOWN 2
// prescaler terminal counts for the four clock selections
`define WKT_PRE_DIV1 5'h00
`define WKT_PRE_DIV8 5'h07
`define WKT_PRE_DIV16 5'h0F
`define WKT_PRE_DIV32 5'h1F
`define WKT_RESP_OKAY 2'h0
`define WKT_RESP_SLVERR 2'h2
`endif

// ### wkt_pkg.sv
package wkt_pkg;
   // writable control fields below the running bits
   typedef struct packed {
      logic auto_trim;
      logic auto_card;
      logic auto_restart;
      logic auto_wake;
      logic [1:0] clock_select;
   } wkt_ctrl_t;
   // low-power card detection and trimming sequencer
   typedef enum logic [2:0] {
      WKT_CD_IDLE = 3'h1,
      WKT_CD_FIELD = 3'h2,
      WKT_CD_TRIM = 3'h4
   } wkt_cd_state_t;
endpackage

// ### wkt_wakeup_timer.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wkt_defs.svh"
module wkt_wakeup_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic lfo_tick,
   input wire logic timer3_tick,
   input wire logic timer3_start,
   input wire logic card_present,
   input wire logic trim_done,
   input wire logic power_down_request,
   output logic field_on,
   output logic trim_start,
   output logic card_detected,
   output logic power_down,
   output logic wakeup_underflow_flag
);
   // ***************************************
   // register bus
   // ***************************************
   logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rdata_next;
   wire logic wr_go = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
   wire logic wr_do = awready_reg & wstrb[0];
   wire logic [5:0] wr_idx = awaddr[7:2];
   wire logic [5:0] rd_idx = araddr[7:2];
   wire logic rd_go = arvalid & ~arready_reg & ~rvalid_reg;
   wire logic [7:0] wb = wdata[7:0];
   wire logic wr_ctrl = wr_do & (wr_idx == `WKT_IDX_CONTROL);
   wire logic wr_stat = wr_do & (wr_idx == `WKT_IDX_STATUS);
   wire logic wr_known = (wr_idx >= `WKT_IDX_T3_RELOAD_HIGH && wr_idx <= `WKT_IDX_RELOAD_LOW)
      || wr_idx == `WKT_IDX_STATUS;
   wire logic rd_known = (rd_idx >= `WKT_IDX_T3_RELOAD_HIGH && rd_idx <= `WKT_IDX_COUNT_LOW)
      || rd_idx == `WKT_IDX_STATUS;

   // ***************************************
   // register state
   // ***************************************
   wkt_pkg::wkt_ctrl_t ctrl_reg;
   logic running_reg;
   logic [15:0] reload_reg, count_reg;
   logic [15:0] t3_reload_reg, t3_count_reg;
   logic t3_run_reg;
   logic [4:0] pre_reg;
   logic flag_reg, card_reg, pdown_reg, field_reg, trim_reg;
   wkt_pkg::wkt_cd_state_t cd_reg;

   // run control: of all writes, only one with the change bit touches running
   wire logic run_write = wr_ctrl & wb[`WKT_BIT_RUN_CHANGE]; // R5
   wire logic start_ev = run_write & wb[`WKT_BIT_RUNNING];

   // prescaler terminal count from the clock field
   wire logic [4:0] pre_lim = (ctrl_reg.clock_select == 2'h0) ? `WKT_PRE_DIV1 : // R15
      (ctrl_reg.clock_select == 2'h1) ? `WKT_PRE_DIV8 :
      (ctrl_reg.clock_select == 2'h2) ? `WKT_PRE_DIV16 : `WKT_PRE_DIV32;
   wire logic wk_tick = running_reg & lfo_tick & (pre_reg == pre_lim);
   wire logic underflow = wk_tick & (count_reg == 16'h0000); // R16
   // detection forces a seamless restart even without auto-restart
   wire logic restart = ctrl_reg.auto_restart | ctrl_reg.auto_card; // R9 R11
   wire logic cd_start = underflow & ctrl_reg.auto_card & (cd_reg == wkt_pkg::WKT_CD_IDLE);
   wire logic t3_load = timer3_start | cd_start; // R10
   wire logic t3_zero = t3_run_reg & timer3_tick & (t3_count_reg == 16'h0000);
   wire logic cd_end = (cd_reg == wkt_pkg::WKT_CD_FIELD) & t3_zero;
   wire logic trim_end = (cd_reg == wkt_pkg::WKT_CD_TRIM) & trim_done;

   // bus handshake; ready pulses for exactly the accepting cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `WKT_RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= `WKT_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         awready_reg <= wr_go;
         if (awready_reg) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? `WKT_RESP_OKAY : `WKT_RESP_SLVERR;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
         arready_reg <= rd_go;
         if (arready_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_known ? `WKT_RESP_OKAY : `WKT_RESP_SLVERR;
            rdata_reg <= rdata_next;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // read mux; the change bit is write-only and reads zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (rd_idx)
         `WKT_IDX_T3_RELOAD_HIGH: rdata_next[7:0] = t3_reload_reg[15:8];
         `WKT_IDX_T3_RELOAD_LOW: rdata_next[7:0] = t3_reload_reg[7:0];
         `WKT_IDX_T3_COUNT_HIGH: rdata_next[7:0] = t3_count_reg[15:8]; // R2
         `WKT_IDX_T3_COUNT_LOW: rdata_next[7:0] = t3_count_reg[7:0]; // R2
         `WKT_IDX_CONTROL: rdata_next[7:0] = {running_reg, 1'b0, ctrl_reg}; // R4
         `WKT_IDX_RELOAD_HIGH: rdata_next[7:0] = reload_reg[15:8];
         `WKT_IDX_RELOAD_LOW: rdata_next[7:0] = reload_reg[7:0];
         `WKT_IDX_COUNT_HIGH: rdata_next[7:0] = count_reg[15:8];
         `WKT_IDX_COUNT_LOW: rdata_next[7:0] = count_reg[7:0];
         `WKT_IDX_STATUS: rdata_next[2:0] = {pdown_reg, card_reg, flag_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // ***************************************
   // software-written registers
   // ***************************************
   // reload bytes only stage a value; counters pick it up at a start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= '0; // R19
         reload_reg <= 16'h0000;
         t3_reload_reg <= 16'h0000;
      end else if (wr_do) begin
         if (wr_idx == `WKT_IDX_CONTROL) ctrl_reg <= wb[5:0];
         if (wr_idx == `WKT_IDX_RELOAD_HIGH) reload_reg[15:8] <= wb; // R16
         if (wr_idx == `WKT_IDX_RELOAD_LOW) reload_reg[7:0] <= wb;
         if (wr_idx == `WKT_IDX_T3_RELOAD_HIGH) t3_reload_reg[15:8] <= wb;
         if (wr_idx == `WKT_IDX_T3_RELOAD_LOW) t3_reload_reg[7:0] <= wb;
      end
   end

   // ***************************************
   // wake-up timer
   // ***************************************
   // a stop write wins over a same-cycle underflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         running_reg <= 1'b0;
         count_reg <= 16'h0000;
         pre_reg <= 5'h00;
      end else if (run_write) begin
         running_reg <= wb[`WKT_BIT_RUNNING]; // R5
         if (start_ev) count_reg <= reload_reg; // R18
         pre_reg <= 5'h00;
      end else if (wk_tick) begin
         pre_reg <= 5'h00;
         if (count_reg != 16'h0000) count_reg <= count_reg - 16'h0001;
         else if (restart) count_reg <= reload_reg; // R11
         else running_reg <= 1'b0; // R19
      end else if (running_reg && lfo_tick) begin
         pre_reg <= pre_reg + 5'h01;
      end
   end

   // ***************************************
   // timer3 as used here
   // ***************************************
   // stops at zero; detection uses its interval as the field-on time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t3_run_reg <= 1'b0;
         t3_count_reg <= 16'h0000;
      end else if (t3_load) begin
         t3_run_reg <= 1'b1;
         t3_count_reg <= t3_reload_reg; // R1
      end else if (t3_zero) begin
         t3_run_reg <= 1'b0;
      end else if (t3_run_reg && timer3_tick) begin
         t3_count_reg <= t3_count_reg - 16'h0001;
      end
   end

   // ***************************************
   // underflow flag and power state
   // ***************************************
   // flag and card status bits clear by writing one; a same-cycle set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'b0;
         card_reg <= 1'b0;
         pdown_reg <= 1'b0;
      end else begin
         if (underflow) flag_reg <= 1'b1; // R12
         else if (wr_stat && wb[`WKT_BIT_FLAG]) flag_reg <= 1'b0;
         if (cd_end && card_present) card_reg <= 1'b1; // R8
         else if (wr_stat && wb[`WKT_BIT_CARD]) card_reg <= 1'b0;
         if (underflow && ctrl_reg.auto_wake) pdown_reg <= 1'b0; // R13 R17
         else if (cd_end && card_present) pdown_reg <= 1'b0; // R8
         else if (cd_end || trim_end) pdown_reg <= ctrl_reg.auto_wake; // R9 R14
         else if (power_down_request) pdown_reg <= 1'b1;
      end
   end

   // ***************************************
   // detection and trimming sequencer
   // ***************************************
   // trimming waits in its own state so power-down, with auto-wake set, follows its end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cd_reg <= wkt_pkg::WKT_CD_IDLE;
         field_reg <= 1'b0;
         trim_reg <= 1'b0;
      end else begin
         trim_reg <= underflow & ctrl_reg.auto_trim; // R6
         field_reg <= cd_start | (field_reg & ~cd_end); // R10
         unique case (cd_reg)
            wkt_pkg::WKT_CD_IDLE: begin
               if (cd_start) cd_reg <= wkt_pkg::WKT_CD_FIELD; // R8 R17
               else if (underflow && ctrl_reg.auto_trim) cd_reg <= wkt_pkg::WKT_CD_TRIM;
            end
            wkt_pkg::WKT_CD_FIELD: begin
               if (cd_end) cd_reg <= wkt_pkg::WKT_CD_IDLE;
            end
            wkt_pkg::WKT_CD_TRIM: begin
               if (trim_done) cd_reg <= wkt_pkg::WKT_CD_IDLE;
            end
            default: cd_reg <= wkt_pkg::WKT_CD_IDLE;
         endcase
      end
   end

   assign awready = awready_reg;
   assign wready = awready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;
   assign field_on = field_reg;
   assign trim_start = trim_reg;
   assign card_detected = card_reg;
   assign power_down = pdown_reg;
   assign wakeup_underflow_flag = flag_reg;

   // ***************************************
   // checks
   // ***************************************
   property p_start_load;
      @(posedge aclk) disable iff (!aresetn)
      start_ev |=> running_reg && count_reg == $past(reload_reg);
   endproperty
   a_start_load: assert property (p_start_load) else $error("start did not load reload"); // R18

   property p_run_hold;
      @(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && !wb[`WKT_BIT_RUN_CHANGE] && !wk_tick) |=> $stable(running_reg);
   endproperty
   a_run_hold: assert property (p_run_hold) // R5
      else $error("running changed without change bit");

   property p_flag;
      @(posedge aclk) disable iff (!aresetn)
      underflow |=> flag_reg;
   endproperty
   a_flag: assert property (p_flag) else $error("underflow flag not set"); // R12

   property p_trim;
      @(posedge aclk) disable iff (!aresetn)
      (underflow && ctrl_reg.auto_trim) |=> trim_reg ##1 !trim_reg;
   endproperty
   a_trim: assert property (p_trim) else $error("trim start not pulsed"); // R6

   property p_stop;
      @(posedge aclk) disable iff (!aresetn)
      (underflow && !restart && !run_write) |=> !running_reg && count_reg == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("timer did not stop at zero"); // R11

   property p_restart;
      @(posedge aclk) disable iff (!aresetn)
      (underflow && restart && !run_write) |=> running_reg && count_reg == $past(reload_reg);
   endproperty
   a_restart: assert property (p_restart) else $error("timer did not restart"); // R9

   property p_wake;
      @(posedge aclk) disable iff (!aresetn)
      (underflow && ctrl_reg.auto_wake) |=> !pdown_reg;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on underflow"); // R13

   sequence s_cd_begin;
      cd_start ##1 (field_reg && t3_run_reg);
   endsequence
   property p_field;
      @(posedge aclk) disable iff (!aresetn)
      cd_start |-> s_cd_begin;
   endproperty
   a_field: assert property (p_field) else $error("field not on with timer3"); // R10

   property p_no_card;
      @(posedge aclk) disable iff (!aresetn)
      (cd_end && !card_present && !underflow) |=> pdown_reg == $past(ctrl_reg.auto_wake);
   endproperty
   a_no_card: assert property (p_no_card) else $error("power state after detection wrong"); // R14

   property p_t3_read;
      @(posedge aclk) disable iff (!aresetn)
      (arready_reg && rd_idx == `WKT_IDX_T3_COUNT_LOW)
         |=> rdata_reg[7:0] == $past(t3_count_reg[7:0]);
   endproperty
   a_t3_read: assert property (p_t3_read) else $error("timer3 low byte readback wrong"); // R2

   // a staged reload only reaches timer3 through a start
   property p_t3_load;
      @(posedge aclk) disable iff (!aresetn)
      t3_load |=> t3_run_reg && t3_count_reg == $past(t3_reload_reg);
   endproperty
   a_t3_load: assert property (p_t3_load) else $error("timer3 start did not load"); // R1

   property p_run_read;
      @(posedge aclk) disable iff (!aresetn)
      (arready_reg && rd_idx == `WKT_IDX_CONTROL) |=> rdata_reg[7] == $past(running_reg);
   endproperty
   a_run_read: assert property (p_run_read) else $error("running bit readback wrong"); // R4

   // the prescaler advances once per oscillator tick between timer ticks
   property p_prescale;
      @(posedge aclk) disable iff (!aresetn)
      (lfo_tick && !wk_tick && running_reg && !run_write) |=> pre_reg == $past(pre_reg) + 5'h01;
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler did not advance"); // R15

   property p_stop_write;
      @(posedge aclk) disable iff (!aresetn)
      (run_write && !wb[`WKT_BIT_RUNNING]) |=> !running_reg;
   endproperty
   a_stop_write: assert property (p_stop_write) else $error("stop write ignored"); // R5
endmodule // wkt_wakeup_timer
`default_nettype wire

// ### wakeup_timer_and_timer3_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "wkt_defs.svh"
module wakeup_timer_and_timer3_readout_test;
   // ********************
   // stimulus and wiring
   // ********************
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [4:0] pls = 5'h00; // lfo, t3 tick, t3 start, trim done, power-down request
   logic card_present = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, field_on, trim_start;
   logic card_detected, power_down, wakeup_underflow_flag;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] lfsr_q = 16'h30F2; // seed 12530
   logic [15:0] t3, t;
   logic [7:0] rl;
   int num_errors = 0, n_checks = 0, cnt, trim_seen = 0;

   always #12.5 aclk = ~aclk;

   wkt_wakeup_timer DUT (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .lfo_tick(pls[0]), .timer3_tick(pls[1]), .timer3_start(pls[2]),
      .card_present(card_present), .trim_done(pls[3]), .power_down_request(pls[4]),
      .field_on(field_on), .trim_start(trim_start), .card_detected(card_detected),
      .power_down(power_down), .wakeup_underflow_flag(wakeup_underflow_flag));

   // trim launch is a single-cycle pulse, so count it on every edge
   always @(posedge aclk) begin
      if (trim_start === 1'h1) trim_seen++;
   end

   // ********************
   // helpers
   // ********************
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // lfo ticks per timer decrement for each clock selection
   function automatic int divof(input logic [1:0] s);
      return (s == 2'h0) ? 1 : (4 << s);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // address and data go out together; each released once taken
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge aclk); while (awready !== 1'h1);
      chk(wready, 1'h1);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge aclk); while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk); // one idle edge so the next call never re-drives in this step
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
      araddr <= {idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk(rdata, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk); // one idle edge so the next call never re-drives in this step
   endtask

   // idle edges after the pulse let the one-cycle-late effects settle
   task automatic pulse(input int k);
      pls[k] <= 1'h1;
      @(posedge aclk);
      pls[k] <= 1'h0;
      repeat (3) @(posedge aclk);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 20000);
      num_errors++;
      close_out();
   end

   // ********************
   // scenarios
   // ********************
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(`WKT_IDX_CONTROL, 8'h00, `WKT_RESP_OKAY);
      rd(`WKT_IDX_STATUS, 8'h00, `WKT_RESP_OKAY);
      rd(`WKT_IDX_RELOAD_HIGH, 8'h00, `WKT_RESP_OKAY);
      rd(6'h00, 8'h00, `WKT_RESP_SLVERR);
      wr(6'h00, 8'hFF, `WKT_RESP_SLVERR);
      // timer3: reload copied only at start, count read back in two bytes
      lfsr_q = lfsr_step(lfsr_q);
      t3 = lfsr_q | 16'h0100;
      wr(`WKT_IDX_T3_RELOAD_HIGH, t3[15:8], `WKT_RESP_OKAY);
      wr(`WKT_IDX_T3_RELOAD_LOW, t3[7:0], `WKT_RESP_OKAY);
      pulse(2);
      rd(`WKT_IDX_T3_COUNT_HIGH, t3[15:8], `WKT_RESP_OKAY);
      rd(`WKT_IDX_T3_COUNT_LOW, t3[7:0], `WKT_RESP_OKAY);
      wr(`WKT_IDX_T3_RELOAD_LOW, ~t3[7:0], `WKT_RESP_OKAY);
      repeat (5) pulse(1);
      t = t3 - 16'h0005;
      rd(`WKT_IDX_T3_COUNT_HIGH, t[15:8], `WKT_RESP_OKAY);
      rd(`WKT_IDX_T3_COUNT_LOW, t[7:0], `WKT_RESP_OKAY);
      // one-shot wake-up run: stops after reload+1 ticks
      lfsr_q = lfsr_step(lfsr_q);
      rl = {6'h00, lfsr_q[1:0]} + 8'h01;
      wr(`WKT_IDX_RELOAD_HIGH, 8'h00, `WKT_RESP_OKAY);
      wr(`WKT_IDX_RELOAD_LOW, rl, `WKT_RESP_OKAY);
      wr(`WKT_IDX_CONTROL, 8'h80, `WKT_RESP_OKAY);
      rd(`WKT_IDX_CONTROL, 8'h00, `WKT_RESP_OKAY);
      wr(`WKT_IDX_CONTROL, 8'hC0, `WKT_RESP_OKAY);
      rd(`WKT_IDX_CONTROL, 8'h80, `WKT_RESP_OKAY);
      rd(`WKT_IDX_COUNT_LOW, rl, `WKT_RESP_OKAY);
      repeat (rl) pulse(0);
      chk(wakeup_underflow_flag, 1'h0);
      pulse(0);
      chk(wakeup_underflow_flag, 1'h1);
      rd(`WKT_IDX_CONTROL, 8'h00, `WKT_RESP_OKAY);
      wr(`WKT_IDX_STATUS, 8'h01, `WKT_RESP_OKAY);
      chk(wakeup_underflow_flag, 1'h0);
      // every clock selection, auto-restart keeps the timer running
      for (int s = 0; s < 4; s++) begin
         wr(`WKT_IDX_RELOAD_LOW, 8'h01, `WKT_RESP_OKAY);
         wr(`WKT_IDX_CONTROL, {2'h3, 4'h2, s[1:0]}, `WKT_RESP_OKAY);
         cnt = 0;
         while (wakeup_underflow_flag !== 1'h1 && cnt < 100) begin
            pulse(0);
            cnt++;
         end
         chk(cnt, 2 * divof(s[1:0]));
         rd(`WKT_IDX_CONTROL, {2'h2, 4'h2, s[1:0]}, `WKT_RESP_OKAY);
         wr(`WKT_IDX_CONTROL, 8'h40, `WKT_RESP_OKAY);
         wr(`WKT_IDX_STATUS, 8'h01, `WKT_RESP_OKAY);
      end
      // trimming with and without automatic wake
      pulse(4);
      chk(power_down, 1'h1);
      wr(`WKT_IDX_RELOAD_LOW, 8'h00, `WKT_RESP_OKAY);
      wr(`WKT_IDX_CONTROL, 8'hE4, `WKT_RESP_OKAY);
      pulse(0);
      chk(trim_seen, 1);
      chk(power_down, 1'h0);
      pulse(3);
      chk(power_down, 1'h1);
      wr(`WKT_IDX_CONTROL, 8'hE0, `WKT_RESP_OKAY);
      pulse(0);
      pulse(3);
      chk(trim_seen, 2);
      chk(power_down, 1'h0);
      // card detection: field window from timer3, card found then none
      wr(`WKT_IDX_STATUS, 8'h03, `WKT_RESP_OKAY);
      wr(`WKT_IDX_T3_RELOAD_HIGH, 8'h00, `WKT_RESP_OKAY);
      wr(`WKT_IDX_T3_RELOAD_LOW, 8'h02, `WKT_RESP_OKAY);
      card_present <= 1'h1;
      wr(`WKT_IDX_CONTROL, 8'hD4, `WKT_RESP_OKAY);
      for (int r = 0; r < 2; r++) begin
         pulse(0);
         chk(field_on, 1'h1);
         cnt = 0;
         while (field_on === 1'h1 && cnt < 10) begin
            pulse(1);
            cnt++;
         end
         chk(cnt, 32'h3);
         chk(card_detected, r == 0);
         chk(power_down, r[0]);
         rd(`WKT_IDX_CONTROL, 8'h94, `WKT_RESP_OKAY);
         card_present <= 1'h0;
         // clear the sticky card bit so the empty pass must leave it low
         wr(`WKT_IDX_STATUS, 8'h02, `WKT_RESP_OKAY);
      end
      chk(trim_seen, 2);
      wr(`WKT_IDX_CONTROL, 8'h40, `WKT_RESP_OKAY);
      close_out();
   end
endmodule // wakeup_timer_and_timer3_readout_test
`default_nettype wire
